//--- dd_regs.sv
// digital port and decimation registers behind an APB slave
// assumes: nonvolatile memory answers one cycle after nvm_rd_en,
// gpio pins are asynchronous, conv_ready_n is on pclk
`timescale 1ns/1ps
module dd_regs #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     nvm_rd_en,
  output logic      [11:0]         nvm_addr,
  input  wire logic [7:0]          nvm_rdata,
  input  wire logic [7:0]          gpio_in,
  output logic      [7:0]          gpio_out,
  output logic      [7:0]          gpio_oe,
  input  wire logic                conv_ready_n,
  output logic      [10:0]         decimation_ratio,
  output logic                     data_format_unipolar,
  output logic      [1:0]          settling_mode,
  output logic                     flash_write_en,
  output logic                     config_loading
);

  if (ADDR_W < 6) begin : g_chk
    $error("dd_regs: ADDR_W too small for register map");
  end

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    addr_hit = (a == ADDR_W'({idx, 2'h0}));
  endfunction : addr_hit

  dd_pkg::dd_state_t state;
  logic [2:0]        ld_idx;
  logic [7:0]        gp_port_data;
  logic [7:0]        gp_port_direction;
  logic [7:0]        decimation_low;
  logic [6:0]        mode_cfg;
  logic [7:0]        gpio_meta;
  logic [7:0]        gpio_sync;
  logic              after_rst;

  wire loading  = (state == dd_pkg::DD_LOAD);
  wire sel_data = addr_hit(paddr, dd_pkg::IDX_PORT_DATA);
  wire sel_dir  = addr_hit(paddr, dd_pkg::IDX_PORT_DIR);
  wire sel_decl = addr_hit(paddr, dd_pkg::IDX_DEC_LOW);
  wire sel_mode = addr_hit(paddr, dd_pkg::IDX_MODE_DEC);
  wire mapped   = sel_data | sel_dir | sel_decl | sel_mode;
  wire apb_done = psel & penable & pready;
  wire apb_we   = apb_done & pwrite & mapped & pstrb[0];
  wire ld_cap   = loading & (ld_idx != 3'h0);
  wire [7:0] mode_byte = {conv_ready_n, mode_cfg};

  // pin levels, not the written value, on reads
  wire [7:0] rd_byte = sel_data ? gpio_sync :
                       sel_dir  ? gp_port_direction :
                       sel_decl ? decimation_low :
                       sel_mode ? mode_byte : 8'h00;

  assign pready    = ~loading;
  assign pslverr   = psel & penable & ~mapped;
  assign nvm_rd_en = loading & (ld_idx < dd_pkg::NUM_REGS);
  assign nvm_addr  = {dd_pkg::NVM_PAGE,
                      dd_pkg::IDX_PORT_DATA + {5'h00, ld_idx}};
  assign config_loading = loading;

  assign gpio_out = gp_port_data;
  // bit n pairs with pin n
  assign gpio_oe = ~gp_port_direction;
  assign decimation_ratio = {mode_cfg[dd_pkg::MODE_DECHI_HI:0],
                             decimation_low};
  assign data_format_unipolar = mode_cfg[dd_pkg::MODE_FORMAT_BIT];
  assign settling_mode = mode_cfg[dd_pkg::MODE_SMODE_HI:
                                  dd_pkg::MODE_SMODE_LO];
  assign flash_write_en = mode_cfg[dd_pkg::MODE_WREN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= dd_pkg::DD_LOAD;
      ld_idx <= 3'h0;
    end else begin
      case (state)
        dd_pkg::DD_LOAD: begin
          ld_idx <= ld_idx + 3'h1;
          if (ld_idx == dd_pkg::NUM_REGS) begin
            state <= dd_pkg::DD_RUN;
          end
        end
        dd_pkg::DD_RUN: begin
          ld_idx <= ld_idx;
        end
        default: begin
          state <= dd_pkg::DD_LOAD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      after_rst <= 1'b1;
    else
      after_rst <= 1'b0;
  end

  // two-stage pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_meta <= 8'h00;
      gpio_sync <= 8'h00;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  // factory value until the page image lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gp_port_data <= dd_pkg::RST_PORT_DATA;
    else if (ld_cap && ld_idx == 3'h1)
      gp_port_data <= nvm_rdata;
    else if (apb_we && sel_data)
      gp_port_data <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gp_port_direction <= dd_pkg::RST_PORT_DIR;
    else if (ld_cap && ld_idx == 3'h2)
      gp_port_direction <= nvm_rdata;
    else if (apb_we && sel_dir)
      gp_port_direction <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      decimation_low <= dd_pkg::RST_DEC_LOW;
    else if (ld_cap && ld_idx == 3'h3)
      decimation_low <= nvm_rdata;
    else if (apb_we && sel_decl)
      decimation_low <= pwdata[7:0];
  end

  // mode default; ready bit is read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_cfg <= dd_pkg::RST_MODE_DEC[6:0];
    else if (ld_cap && ld_idx == 3'h4)
      mode_cfg <= nvm_rdata[6:0];
    else if (apb_we && sel_mode)
      mode_cfg <= pwdata[6:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !apb_done)
      prdata <= {24'h00_0000, rd_byte};
  end

  // assertions
  wire rd_data_done = apb_done & ~pwrite & sel_data;

  a_load_page_zero: assert property (@(posedge pclk) disable iff (!presetn)
    nvm_rd_en |-> nvm_addr[11:8] == dd_pkg::NVM_PAGE)
    else $error("load read outside page zero");

  a_load_dir_image: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_cap && ld_idx == 3'h2) |=> gp_port_direction == $past(nvm_rdata))
    else $error("direction not loaded from page");

  a_load_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    after_rst |-> ##[1:6] !loading)
    else $error("load did not finish");

  a_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    after_rst |-> gp_port_data == dd_pkg::RST_PORT_DATA &&
      {1'b0, mode_cfg} == dd_pkg::RST_MODE_DEC)
    else $error("factory default wrong after reset");

  // written value reaches pins as output
  a_write_drives_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_data) |=> gpio_out == $past(pwdata[7:0]))
    else $error("port data write not on pins");

  a_read_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
    rd_data_done |-> prdata[7:0] == $past(gpio_sync))
    else $error("port read not pin level");

  a_dir_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_dir) |=> gpio_oe == ~$past(pwdata[7:0]))
    else $error("direction polarity wrong");

  a_powerup_inputs: assert property (@(posedge pclk) disable iff (!presetn)
    after_rst |-> gpio_oe == 8'h00)
    else $error("pin driven after reset");

  a_ratio_low: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_decl) |=> decimation_ratio[7:0] == $past(pwdata[7:0])
      && $stable(decimation_ratio[10:8]))
    else $error("decimation low byte not applied");

  a_pin_mapping: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_dir && !pwdata[7]) |=> gpio_oe[7] &&
      gpio_oe[6:0] == ~$past(pwdata[6:0]))
    else $error("pin seven mapping wrong");

  // port data takes the page image
  a_load_data_image: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_cap && ld_idx == 3'h1) |=> gp_port_data == $past(nvm_rdata))
    else $error("port data not loaded from page");

  // low decimation takes the page image
  a_load_declow_image: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_cap && ld_idx == 3'h3) |=> decimation_low == $past(nvm_rdata))
    else $error("decimation low not loaded from page");

  // mode bits take the page image
  a_load_mode_image: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_cap && ld_idx == 3'h4) |=> mode_cfg == $past(nvm_rdata[6:0]))
    else $error("mode not loaded from page");

  // first read is the port data byte
  a_load_first_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (nvm_rd_en && ld_idx == 3'h0) |->
      nvm_addr == {dd_pkg::NVM_PAGE, dd_pkg::IDX_PORT_DATA})
    else $error("first load address wrong");

  // data write leaves the enables alone
  a_data_keeps_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_data) |=> $stable(gpio_oe))
    else $error("data write changed direction");

  // pins keep their value between data writes
  a_out_stable_run: assert property (@(posedge pclk) disable iff (!presetn)
    (!loading && !(apb_we && sel_data)) |=> $stable(gpio_out))
    else $error("pin value changed without write");

  // a port read leaves the driven value
  a_read_keeps_data: assert property (@(posedge pclk) disable iff (!presetn)
    rd_data_done |=> $stable(gpio_out))
    else $error("port read changed pin value");

  // direction write leaves the pin values
  a_dir_keeps_data: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_dir) |=> $stable(gpio_out))
    else $error("direction write changed pin value");

  // outside the page load, enables change only on a direction write
  a_oe_stable_run: assert property (@(posedge pclk) disable iff (!presetn)
    (!loading && !(apb_we && sel_dir)) |=> $stable(gpio_oe))
    else $error("direction changed without write");

  a_reset_dir_ones: assert property (@(posedge pclk) disable iff (!presetn)
    after_rst |-> gp_port_direction == dd_pkg::RST_PORT_DIR)
    else $error("direction default wrong after reset");

  a_ratio_high: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_we && sel_mode) |=> decimation_ratio[10:8] == $past(pwdata[2:0])
      && $stable(decimation_ratio[7:0]))
    else $error("decimation high bits not applied");

  c_write_data: cover property (@(posedge pclk) disable iff (!presetn)
    apb_we && sel_data);
  c_read_pins: cover property (@(posedge pclk) disable iff (!presetn)
    rd_data_done);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
  c_mode_write: cover property (@(posedge pclk) disable iff (!presetn)
    apb_we && sel_mode);
  c_load_done: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(loading));

endmodule : dd_regs

//--- dd_pkg.sv
// package: offsets, reset values, field positions and states of the
// digital port and decimation register slice
// assumes: APB data 32 bits, each register one word at index*4
package dd_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_DATA = 8'h06;
  localparam logic [7:0] IDX_PORT_DIR  = 8'h07;
  localparam logic [7:0] IDX_DEC_LOW   = 8'h08;
  localparam logic [7:0] IDX_MODE_DEC  = 8'h09;
  // factory defaults used while the nonvolatile page is being read
  localparam logic [7:0] RST_PORT_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_DIR  = 8'hFF;
  localparam logic [7:0] RST_DEC_LOW   = 8'h80;
  localparam logic [7:0] RST_MODE_DEC  = 8'h07;
  // mode register fields
  localparam int unsigned MODE_READY_BIT  = 7;
  localparam int unsigned MODE_FORMAT_BIT = 6;
  localparam int unsigned MODE_SMODE_HI   = 5;
  localparam int unsigned MODE_SMODE_LO   = 4;
  localparam int unsigned MODE_WREN_BIT   = 3;
  localparam int unsigned MODE_DECHI_HI   = 2;
  // nonvolatile page holding the reset image, and register count
  localparam logic [3:0] NVM_PAGE = 4'h0;
  localparam logic [2:0] NUM_REGS = 3'h4;
  typedef enum logic [0:0] {DD_LOAD, DD_RUN} dd_state_t;
endpackage : dd_pkg

//--- dd_nvm.sv
// nonvolatile page model holding the reset image
// assumes: read answered on the edge after nvm_rd_en
`timescale 1ns/1ps
module dd_nvm (
  input  wire logic        pclk,
  input  wire logic        nvm_rd_en,
  input  wire logic [11:0] nvm_addr,
  output logic      [7:0]  nvm_rdata
);
  logic [7:0] img;
  always_comb begin
    case (nvm_addr)
      12'h006: img = 8'h00;
      12'h007: img = 8'hFF;
      12'h008: img = 8'h96;
      12'h009: img = 8'h07;
      default: img = 8'h5A;
    endcase
  end
  // released data line toggles
  always_ff @(posedge pclk) begin
    if (nvm_rd_en) nvm_rdata <= img;
    else nvm_rdata <= ~nvm_rdata;
  end
endmodule : dd_nvm

//--- testbench.sv
// self-checking bench for the port and decimation registers
// assumes: dd_regs and dd_nvm compiled first
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, er;
  logic        dfmt, wren, cfg_load;
  logic [1:0]  smode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, nvm_rd_en, conv_ready_n;
  logic [11:0] nvm_addr;
  logic [7:0]  nvm_rdata, gpio_out, gpio_oe, pin_ext;
  wire  [7:0]  pins;
  logic [10:0] decimation_ratio;
  int          errors, n_tests;
  assign pins = (gpio_out & gpio_oe) | (pin_ext & ~gpio_oe);
  dd_regs i_dd_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_rd_en(nvm_rd_en), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
    .gpio_in(pins), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .conv_ready_n(conv_ready_n), .decimation_ratio(decimation_ratio),
    .data_format_unipolar(dfmt), .settling_mode(smode),
    .flash_write_en(wren), .config_loading(cfg_load));
  dd_nvm i_dd_nvm (.pclk(pclk), .nvm_rd_en(nvm_rd_en),
    .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k == 50) begin
      errors++;
      $display("[FAIL] apb ready expected 1 seen timeout");
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset;
    check("oe in reset", 8'h00, gpio_oe);
    check("out in reset", 8'h00, gpio_out);
    check("loading in reset", 1'b1, cfg_load);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h01C, 32'h0, 4'hF);
    check("dir after load", 32'h0000_00FF, rd);
    apb(1'b0, 12'h024, 32'h0, 4'hF);
    check("mode after load", 32'h0000_0007, rd);
    check("ratio from page", 11'h796, decimation_ratio);
    check("load done", 1'b0, cfg_load);
  endtask : t_reset
  task automatic t_gpio;
    apb(1'b1, 12'h01C, 32'hFFFF_FFF0, 4'hF);
    apb(1'b1, 12'h018, 32'h0000_00A5, 4'hF);
    @(posedge pclk);
    check("oe per pin", 8'h0F, gpio_oe);
    check("out per pin", 8'hA5, gpio_out);
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h018, 32'h0, 4'hF);
    check("pin readback", 32'h0000_0035, rd);
    check("pins not reg", 1'b1, rd[7:0] !== 8'hA5);
  endtask : t_gpio
  task automatic t_dec;
    apb(1'b1, 12'h020, 32'h0000_0014, 4'hF);
    apb(1'b1, 12'h024, 32'h0000_0005, 4'hF);
    @(posedge pclk);
    check("ratio", 11'h514, decimation_ratio);
    apb(1'b1, 12'h024, 32'h0000_0002, 4'hE);
    apb(1'b0, 12'h024, 32'h0, 4'hF);
    check("mode kept", 32'h0000_0005, rd);
    conv_ready_n <= 1'b1;
    apb(1'b1, 12'h024, 32'h0000_005D, 4'hF);
    apb(1'b0, 12'h024, 32'h0, 4'hF);
    check("mode bits", 32'h0000_00DD, rd);
    check("ratio high kept", 11'h514, decimation_ratio);
    check("unipolar", 1'b1, dfmt);
    check("settling", 2'h1, smode);
    check("flash wren", 1'b1, wren);
    apb(1'b0, 12'h030, 32'h0, 4'hF);
    check("unmapped err", 1'b1, er);
    check("unmapped data", 32'h0, rd);
  endtask : t_dec
  task automatic t_reload;
    apb(1'b1, 12'h020, 32'h0000_0033, 4'hF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("ratio in reset", 11'h780, decimation_ratio);
    check("oe in mid reset", 8'h00, gpio_oe);
    presetn <= 1'b1;
    apb(1'b0, 12'h020, 32'h0, 4'hF);
    check("dec low reload", 32'h0000_0096, rd);
    check("dir reload", 8'h00, gpio_oe);
  endtask : t_reload
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    conv_ready_n = 1'b0;
    pin_ext = 8'h3C;
    repeat (2) @(posedge pclk);
    t_reset;
    t_gpio;
    t_dec;
    t_reload;
    wrap_up;
  end
  initial begin
    #20000;
    errors++;
    wrap_up;
  end
endmodule : testbench
